// file: dps_regs.svh
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

// Data memory window in the core address map.
`define DPS_WIN_LO        16'h1000
`define DPS_WIN_HI        16'h107F

// Row layout: only the low offset bits may differ inside one row.
`define DPS_OFS_W         4
`define DPS_ROW_LSB       4
`define DPS_ROW_MSB       6
`define DPS_LATCH_ENTRIES 16
`define DPS_LAST_ENTRY    4'hF
`define DPS_MAX_LOADS     6'h20

// Programming time and its cycle count at the core clock.
`define DPS_CLK_PERIOD_NS 25
`define DPS_PROG_TIME_NS  100000
`define DPS_PROG_CYCLES   ((`DPS_PROG_TIME_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)

`endif

// file: dps_pkg.sv
package dps_pkg;

    typedef logic [6:0]  dps_aidx_t;
    typedef logic [11:0] dps_tmr_t;
    typedef logic [3:0]  dps_ofs_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dps_req_s;

    typedef struct packed {
        logic busy;
        logic complete;
        logic wait_mode;
        logic halt_mode;
    } dps_status_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG,
        ST_COMMIT,
        ST_HALT
    } dps_state_e;

endpackage

// file: dps_cell_array.sv
`timescale 1ns/1ps
`default_nettype none

module dps_cell_array import dps_pkg::*; (
    // Clock
    input  wire logic      core_clk_in,
    // Write port
    input  wire logic      wr_en_in,
    input  wire dps_aidx_t wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    // Read port
    input  wire dps_aidx_t rd_addr_in,
    output logic [7:0]     rd_data_out
);

    // Nonvolatile cells: contents survive reset, so they carry none.
    logic [7:0] cells [0:127];

    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            cells[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = cells[rd_addr_in];

endmodule

`default_nettype wire

// file: dps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.svh"

module dps_sequencer import dps_pkg::*; (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    // Core memory access
    input  wire dps_req_s    core_req_in,
    input  wire logic        start_prog_in,
    input  wire logic        abort_in,
    input  wire logic        wait_for_interrupt_instr_in,
    input  wire logic        halt_instr_in,
    // Answers and status
    output logic [7:0]       rdata_out,
    output logic             rvalid_out,
    output logic             rd_refused_out,
    output logic             ld_ack_out,
    output dps_status_s      status_out
);

    dps_state_e                               state_q, state_d;
    dps_tmr_t                                 tmr_q, tmr_d;
    dps_ofs_t                                 idx_q, idx_d;
    logic [2:0]                               row_q, row_d;
    logic [5:0]                               load_cnt_q, load_cnt_d;
    logic                                     complete_q, complete_d;
    logic                                     wait_q, wait_d;
    logic                                     busy_q, busy_d;
    logic                                     halt_q, halt_d;
    logic [7:0]                               rdata_q, rdata_d;
    logic                                     rvalid_q, rvalid_d;
    logic                                     refused_q, refused_d;
    logic                                     ack_q, ack_d;
    logic [`DPS_LATCH_ENTRIES-1:0][7:0]       lat_q, lat_d;
    logic [`DPS_LATCH_ENTRIES-1:0]            lval_q, lval_d;
    logic                                     clr_lat;
    logic                                     in_win;
    logic                                     rd_hit;
    logic                                     ld_hit;
    logic                                     ld_take;
    logic                                     arr_we;
    dps_aidx_t                                arr_waddr;
    logic [7:0]                               arr_rdata;

    assign in_win   = core_req_in.req && (core_req_in.addr >= `DPS_WIN_LO)
                      && (core_req_in.addr <= `DPS_WIN_HI);
    assign rd_hit   = in_win && !core_req_in.we;
    assign ld_hit   = in_win && core_req_in.we;
    // Loads go to latches only when idle and below the load limit.
    assign ld_take  = ld_hit && (state_q == ST_IDLE) && !halt_instr_in && !abort_in
                      && (load_cnt_q < `DPS_MAX_LOADS);

    // Commit walks every latch slot once, writing the valid ones.
    assign arr_we    = (state_q == ST_COMMIT) && lval_q[idx_q]
                       && !halt_instr_in;
    assign arr_waddr = {row_q, idx_q};

    dps_cell_array u_cells (
        .core_clk_in (core_clk_in),
        .wr_en_in    (arr_we),
        .wr_addr_in  (arr_waddr),
        .wr_data_in  (lat_q[idx_q]),
        .rd_addr_in  (core_req_in.addr[`DPS_ROW_MSB:0]),
        .rd_data_out (arr_rdata)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `DPS_LATCH_ENTRIES; gi++) begin : g_lat
            logic hit;
            assign hit       = ld_take && (core_req_in.addr[`DPS_OFS_W-1:0] == 4'(gi));
            assign lat_d[gi] = hit ? core_req_in.wdata : lat_q[gi];
            assign lval_d[gi] = clr_lat ? 1'b0 : (hit ? 1'b1 : lval_q[gi]);
        end
    endgenerate

    always_comb begin
        state_d    = state_q;
        tmr_d      = tmr_q;
        idx_d      = idx_q;
        row_d      = row_q;
        load_cnt_d = load_cnt_q;
        complete_d = complete_q;
        wait_d     = 1'b0;
        rdata_d    = rdata_q;
        rvalid_d   = 1'b0;
        refused_d  = 1'b0;
        ack_d      = 1'b0;
        clr_lat    = 1'b0;
        if (halt_instr_in || abort_in) begin
            // Programming is dropped on the spot; cells may hold partial data.
            state_d    = halt_instr_in ? ST_HALT : ST_IDLE;
            clr_lat    = 1'b1;
            load_cnt_d = 6'h00;
            complete_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    wait_d = wait_for_interrupt_instr_in;
                    if (rd_hit) begin
                        rvalid_d = 1'b1;
                        rdata_d  = arr_rdata;
                    end
                    if (ld_take) begin
                        ack_d      = 1'b1;
                        load_cnt_d = load_cnt_q + 6'h01;
                        complete_d = 1'b0;
                        if (load_cnt_q == 6'h00) begin
                            row_d = core_req_in.addr[`DPS_ROW_MSB:`DPS_ROW_LSB];
                        end
                    end else if (start_prog_in) begin
                        if (|lval_q) begin
                            state_d    = ST_PROG;
                            tmr_d      = 12'(`DPS_PROG_CYCLES - 1);
                            complete_d = 1'b0;
                            wait_d     = 1'b0;
                        end else begin
                            complete_d = 1'b1;
                        end
                    end
                end
                ST_PROG: begin
                    refused_d = rd_hit;
                    if (tmr_q == 12'h000) begin
                        state_d = ST_COMMIT;
                        idx_d   = 4'h0;
                    end else begin
                        tmr_d = tmr_q - 12'h001;
                    end
                end
                ST_COMMIT: begin
                    refused_d = rd_hit;
                    idx_d     = idx_q + 4'h1;
                    if (idx_q == `DPS_LAST_ENTRY) begin
                        state_d    = ST_IDLE;
                        complete_d = 1'b1;
                        clr_lat    = 1'b1;
                        load_cnt_d = 6'h00;
                    end
                end
                ST_HALT: begin
                    state_d = ST_IDLE;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
        busy_d = (state_d == ST_PROG) || (state_d == ST_COMMIT);
        halt_d = (state_d == ST_HALT);
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q    <= ST_IDLE;
            tmr_q      <= 12'h000;
            idx_q      <= 4'h0;
            row_q      <= 3'h0;
            load_cnt_q <= 6'h00;
            complete_q <= 1'b0;
            wait_q     <= 1'b0;
            busy_q     <= 1'b0;
            halt_q     <= 1'b0;
            rdata_q    <= 8'h00;
            rvalid_q   <= 1'b0;
            refused_q  <= 1'b0;
            ack_q      <= 1'b0;
            lat_q      <= '0;
            lval_q     <= '0;
        end else begin
            state_q    <= state_d;
            tmr_q      <= tmr_d;
            idx_q      <= idx_d;
            row_q      <= row_d;
            load_cnt_q <= load_cnt_d;
            complete_q <= complete_d;
            wait_q     <= wait_d;
            busy_q     <= busy_d;
            halt_q     <= halt_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            refused_q  <= refused_d;
            ack_q      <= ack_d;
            lat_q      <= lat_d;
            lval_q     <= lval_d;
        end
    end

    assign rdata_out      = rdata_q;
    assign rvalid_out     = rvalid_q;
    assign rd_refused_out = refused_q;
    assign ld_ack_out     = ack_q;
    assign status_out     = '{busy: busy_q, complete: complete_q,
                              wait_mode: wait_q, halt_mode: halt_q};

    // Counts the length of each busy stretch for the timing checks.
    logic [12:0] busy_len_q;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_len_q <= 13'h0000;
        end else begin
            busy_len_q <= busy_q ? (busy_len_q + 13'h0001) : 13'h0000;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_quiet;
        !halt_instr_in && !abort_in;
    endsequence

    sequence s_idle_read;
        rd_hit && (state_q == ST_IDLE) ##0 s_quiet;
    endsequence

    sequence s_prog_start;
        (state_q == ST_IDLE) && start_prog_in && !ld_take && (|lval_q) ##0 s_quiet;
    endsequence

    AST_WIN_OUTSIDE: assert property (
        core_req_in.req && !in_win |=> !rvalid_out && !ld_ack_out && !rd_refused_out)
        else $error("Access outside the window was answered.");

    AST_READ_DATA: assert property (
        s_idle_read |=> rvalid_out && (rdata_out == $past(arr_rdata)))
        else $error("Idle read did not return the stored byte.");

    AST_LOAD_LIMIT: assert property (
        ld_hit && (load_cnt_q == `DPS_MAX_LOADS) |=> !ld_ack_out)
        else $error("Latch load accepted beyond the limit.");

    AST_PROG_START: assert property (
        s_prog_start |=> status_out.busy ##1 status_out.busy ##1 (state_q == ST_PROG))
        else $error("Start with loaded latches did not begin programming.");

    AST_PROG_LENGTH: assert property (
        $fell(busy_q) && complete_q |-> busy_len_q == 13'(`DPS_PROG_CYCLES + 16))
        else $error("Programming cycle length is wrong.");

    AST_READ_REFUSED: assert property (
        rd_hit && busy_q ##0 s_quiet |=> rd_refused_out && !rvalid_out)
        else $error("Read during programming was not refused.");

    AST_ABORT: assert property (
        abort_in && !halt_instr_in |=> !status_out.busy && !status_out.complete && (lval_q == '0))
        else $error("Abort did not stop programming.");

    AST_WAIT_DEFER: assert property (
        wait_for_interrupt_instr_in && busy_q ##0 s_quiet |=> !status_out.wait_mode)
        else $error("Wait mode entered during programming.");

    AST_HALT_NOW: assert property (
        halt_instr_in |=> status_out.halt_mode && !status_out.busy && (load_cnt_q == 6'h00))
        else $error("Halt did not stop the sequencer at once.");

    AST_LOAD_IGNORED: assert property (
        ld_hit && busy_q ##0 s_quiet |=> !ld_ack_out && $stable(load_cnt_q))
        else $error("Latch load accepted while busy.");

endmodule

`default_nettype wire

// file: dps_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module dps_core_model import dps_pkg::*; (
    // Clock
    input  wire logic core_clk_in,
    // Requests towards the sequencer
    output var dps_req_s core_req_out,
    output var logic     start_prog_out,
    output var logic     abort_out,
    output var logic     wait_for_interrupt_instr_out,
    output var logic     halt_instr_out
);
    int loads = 0;

    initial begin
        core_req_out = '0;
        start_prog_out = 1'b0;
        abort_out = 1'b0;
        wait_for_interrupt_instr_out = 1'b0;
        halt_instr_out = 1'b0;
    end

    task automatic acc(input logic we, input logic [15:0] addr, input logic [7:0] data);
        @(posedge core_clk_in);
        core_req_out <= '{req: 1'b1, we: we, addr: addr, wdata: data};
        if (we) begin
            loads++;
        end
    endtask

    // A released bus shows the inverse of its last value, so stale data never passes.
    task automatic idle();
        @(posedge core_clk_in);
        core_req_out <= '{req: 1'b0, we: ~core_req_out.we, addr: ~core_req_out.addr,
                          wdata: ~core_req_out.wdata};
    endtask

    // Programming is only started once something was loaded.
    task automatic pulse_start();
        if (loads > 0) begin
            @(posedge core_clk_in);
            start_prog_out <= 1'b1;
            @(posedge core_clk_in);
            start_prog_out <= 1'b0;
            loads = 0;
        end
    endtask

    task automatic levels(input logic ab, input logic wait_for_interrupt_instr, input logic hlt);
        @(posedge core_clk_in);
        abort_out <= ab;
        wait_for_interrupt_instr_out <= wait_for_interrupt_instr;
        halt_instr_out <= hlt;
    endtask
endmodule

`default_nettype wire

// file: dps_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.svh"

module dps_sequencer_tb;
    logic                clk = 1'b0;
    logic                arst_n = 1'b0;
    dps_pkg::dps_req_s   req;
    logic                start, abrt, wait_for_interrupt_instr, hlt, rvalid, refused, ack;
    logic [7:0]          rdata, d;
    logic [15:0]         a;
    dps_pkg::dps_status_s st;
    int                  fails = 0, compares = 0, cyc = 0;
    logic [10:0]         e, expq[$];
    logic [7:0]          mem [0:127];

    always #12.5 clk = ~clk;

    dps_core_model i_dps_core_model (.core_clk_in(clk), .core_req_out(req),
        .start_prog_out(start), .abort_out(abrt), .wait_for_interrupt_instr_out(wait_for_interrupt_instr),
        .halt_instr_out(hlt));

    dps_sequencer i_dps_sequencer (.core_clk_in(clk), .arst_n_in(arst_n), .core_req_in(req),
        .start_prog_in(start), .abort_in(abrt), .wait_for_interrupt_instr_in(wait_for_interrupt_instr),
        .halt_instr_in(hlt), .rdata_out(rdata), .rvalid_out(rvalid),
        .rd_refused_out(refused), .ld_ack_out(ack), .status_out(st));

    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Answer kind is {ack, refused, rvalid}; zero means no answer is due.
    task automatic op(input logic we, input logic [15:0] ad, input logic [7:0] dt,
                      input logic [2:0] k);
        if (k != 3'b000) begin
            expq.push_back({k, (k == 3'b001) ? mem[ad[6:0]] : 8'h00});
        end
        i_dps_core_model.acc(we, ad, dt);
    endtask

    task automatic run_prog(input logic poke);
        int   n;
        logic ww;
        n = 0;
        ww = 1'b0;
        i_dps_core_model.pulse_start();
        fork
            repeat (5000) begin
                @(negedge clk);
                if (st.complete === 1'b1) break;
                if (st.busy === 1'b1) n++;
                if (st.wait_mode !== 1'b0) ww = 1'b1;
            end
            if (poke) begin
                repeat (20) @(posedge clk);
                op(1'b0, 16'h1000, 8'h00, 3'b010);
                op(1'b1, 16'h1050, 8'hA5, 3'b000);
                i_dps_core_model.idle();
                i_dps_core_model.levels(1'b0, 1'b1, 1'b0);
            end
        join
        chk("prog_len", 16'(n), 16'(`DPS_PROG_CYCLES + 16));
        chk("complete", st.complete, 1'b1);
        chk("wait_in_prog", ww, 1'b0);
        if (poke) begin
            @(negedge clk);
            chk("wait_after", st.wait_mode, 1'b1);
            i_dps_core_model.levels(1'b0, 1'b0, 1'b0);
        end
        repeat (3) @(posedge clk);
    endtask

    always @(negedge clk) begin
        if ({ack, refused, rvalid} !== 3'b000) begin
            e = (expq.size() > 0) ? expq.pop_front() : 11'h000;
            chk("answer_kind", {ack, refused, rvalid}, e[10:8]);
            if (rvalid === 1'b1) chk("rdata", rdata, e[7:0]);
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h8610));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk("status_reset", st, 4'h0);
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            mem[i] = d;
            op(1'b1, 16'(16'h1000 + i), d, 3'b100);
        end
        i_dps_core_model.idle();
        run_prog(1'b1);
        for (int i = 0; i < 5; i++) op(1'b0, 16'(16'h1000 + i), 8'h00, 3'b001);
        op(1'b0, 16'h0FFF, 8'h00, 3'b000);
        op(1'b0, 16'h1080, 8'h00, 3'b000);
        // Thirty-three loads in one row: the last one overflows the latch budget.
        for (int i = 0; i < 33; i++) begin
            d = 8'($urandom);
            a = 16'(16'h1070 + i % 16);
            if (i < 32) mem[a[6:0]] = d;
            op(1'b1, a, d, (i < 32) ? 3'b100 : 3'b000);
        end
        i_dps_core_model.idle();
        run_prog(1'b0);
        for (int i = 0; i < 16; i++) op(1'b0, 16'(16'h1070 + i), 8'h00, 3'b001);
        i_dps_core_model.idle();
        mem[7'h21] = 8'h11;
        for (int k = 0; k < 2; k++) begin
            op(1'b1, 16'h1020, 8'h3C, 3'b100);
            i_dps_core_model.idle();
            i_dps_core_model.pulse_start();
            repeat (30) @(posedge clk);
            i_dps_core_model.levels(k == 0, 1'b0, k == 1);
            @(posedge clk);
            @(negedge clk);
            chk("stopped", {st.busy, st.complete, st.halt_mode}, 3'(k));
            op(1'b1, 16'h1021, 8'h00, 3'b000);
            i_dps_core_model.idle();
            i_dps_core_model.levels(1'b0, 1'b0, 1'b0);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("halt_left", st.halt_mode, 1'b0);
            op(1'b1, 16'h1021, 8'h11, 3'b100);
            i_dps_core_model.idle();
        end
        run_prog(1'b0);
        op(1'b0, 16'h1021, 8'h00, 3'b001);
        i_dps_core_model.idle();
        repeat (5) @(posedge clk);
        chk("queue_left", 16'(expq.size()), 16'h0000);
        tally_and_finish();
    end
endmodule

`default_nettype wire
